// ==== bench/shift_unit_props.sv ====
// checker for the shifter apb ports: timing of starts and errors
// assumes it is bound onto shift_unit; one clock, sync reset
`timescale 1ns/1ps
module shift_unit_props (
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        busy_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire        acc = psel_i && penable_i; // access phase
	wire        go  = acc && pwrite_i && paddr_i == 12'h000 && pwdata_i[31] && !busy_o;
	wire [11:0] key = {pwdata_i[30], pwdata_i[13:11], pwdata_i[7:0]}; // form, reg field, opcode
	logic [7:0] run_q; // busy length, guards against a runaway count
	always_ff @(posedge clk_i) begin
		run_q <= (reset_i || !busy_o) ? 8'h00 : run_q + 8'h01;
	end
	a_single_two: assert property (go && key == 12'h4d0 |=> busy_o[*2] ##1 !busy_o)
		else $error("single register shift not two cycles");
	a_mem_fifteen: assert property (go && key == 12'hfd1 |=> busy_o ##14 busy_o ##1 !busy_o)
		else $error("single memory shift not fifteen cycles");
	a_flag_load: assert property (go && pwdata_i[7:0] == 8'h9e |=> busy_o[*3] ##1 !busy_o)
		else $error("flag load not three cycles");
	a_imm_masked: assert property (go && key == 12'h4c0 && pwdata_i[20:16] == 5'h00 |=>
		busy_o[*5] ##1 !busy_o)
		else $error("zero immediate count not five cycles");
	a_busy_bound: assert property (run_q <= 8'd48)
		else $error("busy longer than longest counted form");
	a_busy_cause: assert property ($rose(busy_o) |-> $past(go))
		else $error("busy rose without a start");
	a_err_unmapped: assert property (acc && paddr_i > 12'h018 |->
		pslverr_o && (pwrite_i || prdata_o == 32'h0))
		else $error("unmapped access not refused");
	a_ready_high: assert property (pready_o)
		else $error("wait state inserted");
	c_single: cover property (go && key == 11'h4d0);
	c_load: cover property (go && pwdata_i[7:0] == 8'h9e);
	c_err: cover property (acc && pslverr_o);
endmodule // shift_unit_props
bind shift_unit shift_unit_props u_props (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .busy_o);

// ==== bench/testbench.sv ====
// self-checking bench for the shifter, driven over apb
// assumes shift_unit with zero wait states and busy_o while executing
`timescale 1ns/1ps
module testbench;
	import shift_unit_pkg::*;
	logic        clk_i = 1'b0, reset_i = 1'b1; // clock, sync reset
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd, f0; // rd: last read
	logic        pready_o, pslverr_o, busy_o, err; // err: last pslverr
	int          miscompares = 0, checks = 0, cyc = 0, n;
	// opcodes of the six forms and the expected results per shift and size
	localparam logic [7:0]  OPC [6] = '{8'hd0, 8'hd2, 8'hc0, 8'hd1, 8'hd3, 8'hc1};
	localparam logic [15:0] ER [4]  = '{16'h0002, 16'h8102, 16'h00c0, 16'h2040};
	localparam logic [11:0] EF [4]  = '{12'h801, 12'h800, 12'h001, 12'h001};
	shift_unit DUT (.clk_i, .reset_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
		.prdata_o, .pready_o, .pslverr_o, .busy_o);
	initial forever #12.5 clk_i = ~clk_i;
	// hang guard, far above the whole run
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			wrap_up;
		end
	end
	task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one apb transfer; held until pready is seen at an edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_i);
		psel_i <= 1'b1; penable_i <= 1'b0; pwrite_i <= wr; paddr_i <= a; pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		do @(posedge clk_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0; penable_i <= 1'b0;
	endtask
	// start an instruction and count its busy cycles at falling edges
	task run(input logic [31:0] ctrl, input int exp);
		apb(1'b1, 12'h000, ctrl);
		n = 0;
		while (n < 100) begin
			@(negedge clk_i);
			if (busy_o !== 1'b1) break;
			n++;
		end
		chk("busy cycles", n, exp);
	endtask
	task t_reset;
		apb(1'b0, 12'h014, 32'h0);
		chk("reset flags", rd, 32'h0002);
		chk("mapped error", {31'h0, err}, 32'h0);
		apb(1'b0, 12'h01c, 32'h0);
		chk("unmapped error", {31'h0, err}, 32'h1);
		chk("unmapped data", rd, 32'h0);
		apb(1'b1, 12'h000, 32'h80000012); // not a shift opcode
		apb(1'b0, 12'h018, 32'h0);
		chk("illegal status", rd & 32'h2, 32'h2);
		apb(1'b0, 12'h000, 32'h0);
		chk("command readback", rd, 32'h80000012);
	endtask
	// every opcode of both shifts, count one, register and memory timing mixed
	task t_forms;
		int k;
		for (int r = 0; r < 2; r++) begin
			for (int i = 0; i < 6; i++) begin
				k = r * 2 + (i > 2);
				apb(1'b1, 12'h004, 32'h4081);
				apb(1'b1, 12'h008, 32'h1);
				run({1'b1, i[0], 6'h00, 8'h01, 2'b11, (r ? 3'h7 : 3'h4), 3'h0, OPC[i]},
					(i % 3 == 0) ? (i[0] ? 15 : 2) : (i[0] ? 18 : 6));
				apb(1'b0, 12'h010, 32'h0);
				chk("result", rd, {16'h0, ER[k]});
				apb(1'b0, 12'h014, 32'h0);
				chk("carry and overflow", rd & 32'h801, {20'h0, EF[k]});
			end
		end
	endtask
	// counted shifts; counts above 31 lose their top bits
	task t_multi;
		apb(1'b1, 12'h004, 32'hffeb);
		run(32'h8023f8c1, 8); // three steps right
		apb(1'b0, 12'h010, 32'h0);
		chk("floor divide", rd, 32'hfffd);
		apb(1'b0, 12'h014, 32'h0);
		chk("last carry right", rd & 32'h1, 32'h0);
		apb(1'b1, 12'h004, 32'h0003);
		apb(1'b1, 12'h008, 32'h2f);
		run(32'h8000e0d3, 20); // fifteen steps left from the count register
		apb(1'b0, 12'h010, 32'h0);
		chk("left result", rd, 32'h8000);
		apb(1'b0, 12'h014, 32'h0);
		chk("last carry left", rd & 32'h1, 32'h1);
	endtask
	// zero count leaves flags, then the flag load from the accumulator byte
	task t_flags;
		apb(1'b0, 12'h014, 32'h0);
		f0 = rd;
		apb(1'b1, 12'h004, 32'h007f);
		run(32'h8020e0c0, 5); // immediate 0x20 masks to zero
		apb(1'b0, 12'h014, 32'h0);
		chk("zero count flags", rd, f0);
		apb(1'b1, 12'h00c, 32'hff);
		run(32'h8000009e, 3);
		apb(1'b0, 12'h014, 32'h0);
		chk("loaded flags", rd & 32'h8ff, (f0 & 32'h82a) | 32'hd5);
		apb(1'b1, 12'h00c, 32'h2a); // only unloaded bits set: loaded flags clear
		run(32'h8000009e, 3);
		apb(1'b0, 12'h014, 32'h0);
		chk("cleared flags", rd & 32'h8ff, f0 & 32'h82a);
	endtask
	task wrap_up;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		t_reset;
		t_forms;
		t_multi;
		t_flags;
		wrap_up;
	end
endmodule // testbench

// ==== rtl/shift_step.sv ====
// one shift step for shift_arith_left or shift_arith_right
// assumes a purely combinational use inside the shifter top
`timescale 1ns/1ps
module shift_step
	import shift_unit_pkg::*;
(
	input  wire logic [15:0] value_i,  // operand before this step
	input  wire logic        word_i,   // 1 = word, 0 = byte
	input  wire logic        right_i,  // 1 = arithmetic right
	input  wire logic        sign_i,   // original top bit
	output logic      [15:0] value_o,  // operand after this step
	output logic             out_bit_o // bit shifted out
);
	// msb is bit 7 or bit 15 by size
	always_comb begin
		value_o   = 16'h0000;
		out_bit_o = 1'b0;
		if (right_i) begin
			out_bit_o = value_i[0];
			if (word_i)
				value_o = {sign_i, value_i[15:1]};
			else
				value_o = {8'h00, sign_i, value_i[7:1]};
		end else begin
			out_bit_o = word_i ? value_i[15] : value_i[7];
			if (word_i)
				value_o = {value_i[14:0], 1'b0};
			else
				value_o = {8'h00, value_i[6:0], 1'b0};
		end
	end
endmodule // shift_step

// ==== rtl/shift_unit.sv ====
// shift_arith_left / shift_arith_right / load_flags_from_acc_high unit with apb registers
// assumes an apb master on clk_i; operands come through registers, not memory
//
// Summary of operation
// - left shift is d0/d2/c0/d1/d3/c1 reg 4
// - arithmetic right is same opcodes reg 7
// - left step moves up, zero fills bottom
// - left step sends msb into carry_flag
// - count from immediate or count_register_low
// - only five low count bits used
// - zero count leaves all flags unchanged
// - single left shift: overflow = msb xor carry
// - right step refills top with original sign
// - right step sends lsb into carry_flag
// - right shift divides by two, floor
// - cycles 2/15 single, 5+n/17+n counted
// - flag load restores low flags from acc_high_byte
// - bits 7,6,4,2,0 loaded, mask d5
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`include "shift_unit_map.svh"
module shift_unit
	import shift_unit_pkg::*;
#(
	parameter int COUNT_BITS = 5 // effective count width
)(
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [11:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	output logic             busy_o
);
	// the step counter, the budget and the count masks are sized for five bits;
	// any other width would silently change how long counts wrap
	if (COUNT_BITS != 5) begin : g_count_check
		$error("count width must be five");
	end

	// decode result of an instruction word
	// anything outside the six shift opcodes with reg code 4 or 7 is not ours:
	// rotates and logical right shifts fall through to none
	function automatic shift_op_type decode_op(input logic [7:0] opc, input logic [2:0] regf);
		logic legal;
		legal = (opc == `OPC_B_ONE) || (opc == `OPC_W_ONE) || (opc == `OPC_B_CNT) ||
			(opc == `OPC_W_CNT) || (opc == `OPC_B_IMM) || (opc == `OPC_W_IMM);
		if (legal && regf == `REGF_LEFT)
			return OP_LEFT;
		else if (legal && regf == `REGF_RIGHT)
			return OP_RIGHT;
		return OP_NONE;
	endfunction

	// top bit of an operand: bit 7 for bytes, bit 15 for words
	function automatic logic top_bit(input logic [15:0] value, input logic word);
		return word ? value[15] : value[7];
	endfunction

	// writes to these while a command runs are dropped without an error;
	// software is expected to poll the status word before touching them
	// software-visible state
	logic [31:0]    ctrl_q, ctrl_d;         // last instruction word
	logic [15:0]    operand_q, operand_d;   // operand / result
	logic [7:0]     count_low_q, count_low_d;
	logic [7:0]     acc_high_q, acc_high_d;
	logic [15:0]    flags_q, flags_d;       // status flags word
	logic           illegal_q, illegal_d;   // last command not decoded
	// execution state
	exec_state_type state_q, state_d;
	shift_op_type   op_q, op_d;
	logic           word_q, word_d;
	logic           sign_q, sign_d;         // original msb
	logic [4:0]     steps_q, steps_d;       // shifts left to do
	logic [5:0]     wait_q, wait_d;         // cycles left beyond shifts
	logic           single_q, single_d;     // count came from the "1" form
	logic           ldfl_q, ldfl_d;         // flag load in flight
	logic [4:0]     eff_cnt_q, eff_cnt_d;

	// step datapath
	// one bit per clock keeps the cell tiny; the cycle budget already allows
	// n clocks for the steps, so a barrel shifter would buy nothing here
	logic [15:0] step_val;
	logic        step_bit;
	shift_step u_step (
		.value_i   (operand_q),
		.word_i    (word_q),
		.right_i   (op_q == OP_RIGHT),
		.sign_i    (sign_q),
		.value_o   (step_val),
		.out_bit_o (step_bit)
	);

	// apb: zero wait states, writes to any register dropped while busy, reads still served
	// unmapped addresses answer with pslverr and read as zero; mapped ones never
	// raise an error, even when a write is dropped for being busy
	wire apb_acc  = psel_i && penable_i;
	wire apb_wr   = apb_acc && pwrite_i;
	wire known    = (paddr_i == `REG_CTRL) || (paddr_i == `REG_OPERAND) ||
		(paddr_i == `REG_COUNT_LOW) || (paddr_i == `REG_ACC_HIGH) ||
		(paddr_i == `REG_RESULT) || (paddr_i == `REG_FLAGS) || (paddr_i == `REG_STATUS);
	assign pready_o  = 1'b1;
	assign pslverr_o = apb_acc && !known;
	assign busy_o    = (state_q != ST_IDLE);

	// instruction fields of an incoming command
	wire [7:0] w_opc  = pwdata_i[`CTRL_OPC_LSB +: 8];
	wire [2:0] w_regf = pwdata_i[`CTRL_MODRM_LSB + 3 +: 3];
	wire [7:0] w_imm  = pwdata_i[`CTRL_IMM_LSB +: 8];
	wire       w_mem  = pwdata_i[`CTRL_MEM_BIT];

	// cycle budget: a command spends n step cycles, then wait_q filler cycles,
	// then one done cycle in which the overflow flag or the flag load settles;
	// busy_o covers all of them, so its length is the whole instruction time
	// next-state logic for registers and execution
	always_comb begin
		logic        one_form;
		logic        imm_form;
		logic [4:0]  cnt;
		logic [5:0]  extra;
		shift_op_type dop;
		one_form    = 1'b0;
		imm_form    = 1'b0;
		cnt         = 5'h00;
		extra       = 6'h00;
		dop         = decode_op(w_opc, w_regf);
		ctrl_d      = ctrl_q;
		operand_d   = operand_q;
		count_low_d = count_low_q;
		acc_high_d  = acc_high_q;
		flags_d     = flags_q;
		illegal_d   = illegal_q;
		state_d     = state_q;
		op_d        = op_q;
		word_d      = word_q;
		sign_d      = sign_q;
		steps_d     = steps_q;
		wait_d      = wait_q;
		single_d    = single_q;
		ldfl_d      = ldfl_q;
		eff_cnt_d   = eff_cnt_q;
		unique case (state_q)
			ST_IDLE: begin
				// data registers writable only while idle
				if (apb_wr && paddr_i == `REG_OPERAND)
					operand_d = pwdata_i[15:0];
				if (apb_wr && paddr_i == `REG_COUNT_LOW)
					count_low_d = pwdata_i[7:0];
				if (apb_wr && paddr_i == `REG_ACC_HIGH)
					acc_high_d = pwdata_i[7:0];
				if (apb_wr && paddr_i == `REG_FLAGS)
					flags_d = pwdata_i[15:0];
				if (apb_wr && paddr_i == `REG_CTRL && pwdata_i[`CTRL_GO_BIT]) begin
					ctrl_d    = pwdata_i;
					illegal_d = 1'b0;
					one_form  = (w_opc == `OPC_B_ONE) || (w_opc == `OPC_W_ONE);
					imm_form  = (w_opc == `OPC_B_IMM) || (w_opc == `OPC_W_IMM);
					word_d    = w_opc[0]; // odd opcodes are word forms
					// the top three count bits are dropped, so 32 acts as 0
					if (one_form)
						cnt = 5'd1;
					else if (imm_form)
						cnt = w_imm[4:0];
					else
						cnt = count_low_q[4:0];
					if (w_opc == `OPC_LDFL) begin
						ldfl_d  = 1'b1;
						op_d    = OP_NONE;
						steps_d = 5'd0;
						wait_d  = 6'(`CYC_LDFL - 1);
						state_d = ST_BUSY;
					end else if (dop == OP_NONE) begin
						illegal_d = 1'b1; // unknown command: nothing happens
					end else begin
						op_d      = dop;
						ldfl_d    = 1'b0;
						single_d  = one_form;
						eff_cnt_d = cnt;
						steps_d   = cnt;
						sign_d    = top_bit(operand_q, w_opc[0]);
						// fixed part of the cycle budget; shifts add n more
						// the done cycle is inside this part, not on top of it
						if (one_form)
							extra = w_mem ? 6'(`CYC_ONE_MEM - 1) : 6'(`CYC_ONE_REG - 1);
						else
							extra = w_mem ? 6'(`CYC_CNT_MEM - 1) : 6'(`CYC_CNT_REG - 1);
						wait_d  = one_form ? 6'(extra - 6'd1) : extra;
						state_d = ST_BUSY;
					end
				end
			end
			ST_BUSY: begin
				if (steps_q != 5'd0) begin
					// one bit per cycle, carry keeps the last bit out
					operand_d = step_val;
					flags_d[`FLAG_CARRY] = step_bit;
					steps_d = steps_q - 5'd1;
					// the last step may close the budget too: single register form
					if (steps_q == 5'd1 && wait_q == 6'd0)
						state_d = ST_DONE;
				end else if (wait_q != 6'd0) begin
					wait_d = wait_q - 6'd1;
					// leave one cycle for the done state inside the budget
					if (wait_q == 6'd1)
						state_d = ST_DONE;
				end else begin
					state_d = ST_DONE;
				end
			end
			ST_DONE: begin
				if (ldfl_q) begin
					// bits 7,6,4,2,0 replace, others stay
					flags_d[7:0] = (flags_q[7:0] & ~`FLAG_MASK) |
						(acc_high_q & `FLAG_MASK);
				end else if (single_q || eff_cnt_q == 5'd1) begin
					// overflow is defined for one step only; longer shifts leave it
					if (op_q == OP_LEFT)
						flags_d[`FLAG_OVF] = top_bit(operand_q, word_q) ^
							flags_q[`FLAG_CARRY];
					else
						flags_d[`FLAG_OVF] = 1'b0;
				end
				// zero count: flags untouched, nothing shifted
				ldfl_d  = 1'b0;
				state_d = ST_IDLE;
			end
			default: state_d = ST_IDLE;
		endcase
	end

	// register the whole state
	// synchronous reset only: the flags come back as the fixed power-up word
	// and any command in flight is abandoned with the operand cleared to zero
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ctrl_q      <= 32'h0000_0000;
			operand_q   <= 16'h0000;
			count_low_q <= 8'h00;
			acc_high_q  <= 8'h00;
			flags_q     <= `FLAGS_RESET;
			illegal_q   <= 1'b0;
			state_q     <= ST_IDLE;
			op_q        <= OP_NONE;
			word_q      <= 1'b0;
			sign_q      <= 1'b0;
			steps_q     <= 5'd0;
			wait_q      <= 6'd0;
			single_q    <= 1'b0;
			ldfl_q      <= 1'b0;
			eff_cnt_q   <= 5'd0;
		end else begin
			ctrl_q      <= ctrl_d;
			operand_q   <= operand_d;
			count_low_q <= count_low_d;
			acc_high_q  <= acc_high_d;
			flags_q     <= flags_d;
			illegal_q   <= illegal_d;
			state_q     <= state_d;
			op_q        <= op_d;
			word_q      <= word_d;
			sign_q      <= sign_d;
			steps_q     <= steps_d;
			wait_q      <= wait_d;
			single_q    <= single_d;
			ldfl_q      <= ldfl_d;
			eff_cnt_q   <= eff_cnt_d;
		end
	end

	// read data registered from the setup phase so it is a flop output
	// this costs no wait state; a write cycle leaves the last read data standing
	logic [31:0] rdata_q, rdata_d;
	always_comb begin
		rdata_d = rdata_q;
		if (psel_i && !penable_i && !pwrite_i) begin
			unique case (paddr_i)
				`REG_CTRL:      rdata_d = ctrl_q;
				`REG_OPERAND:   rdata_d = {16'h0000, operand_q};
				`REG_COUNT_LOW: rdata_d = {24'h000000, count_low_q};
				`REG_ACC_HIGH:  rdata_d = {24'h000000, acc_high_q};
				`REG_RESULT:    rdata_d = {16'h0000, operand_q};
				`REG_FLAGS:     rdata_d = {16'h0000, flags_q};
				`REG_STATUS:    rdata_d = {30'h0, illegal_q, busy_o};
				default:        rdata_d = 32'h0000_0000;
			endcase
		end
	end
	always_ff @(posedge clk_i) begin
		if (reset_i)
			rdata_q <= 32'h0000_0000;
		else
			rdata_q <= rdata_d;
	end
	assign prdata_o = rdata_q;
endmodule // shift_unit

// ==== rtl/shift_unit_map.svh ====
// shifter offsets, field positions, reset values and timing counts
// assumes inclusion by the package and the design files; definitions only
`ifndef SHIFT_UNIT_MAP_SVH
`define SHIFT_UNIT_MAP_SVH

// apb register byte addresses
`define REG_CTRL      12'h000
`define REG_OPERAND   12'h004
`define REG_COUNT_LOW 12'h008
`define REG_ACC_HIGH  12'h00c
`define REG_RESULT    12'h010
`define REG_FLAGS     12'h014
`define REG_STATUS    12'h018

// control word fields
`define CTRL_GO_BIT     31
`define CTRL_MEM_BIT    30
`define CTRL_OPC_LSB    0
`define CTRL_MODRM_LSB  8
`define CTRL_IMM_LSB    16

// reg field codes
`define REGF_LEFT  3'h4
`define REGF_RIGHT 3'h7

// primary opcodes
`define OPC_B_ONE 8'hd0
`define OPC_W_ONE 8'hd1
`define OPC_B_CNT 8'hd2
`define OPC_W_CNT 8'hd3
`define OPC_B_IMM 8'hc0
`define OPC_W_IMM 8'hc1
`define OPC_LDFL  8'h9e

// flag bit positions
`define FLAG_CARRY 0
`define FLAG_PAR   2
`define FLAG_AUX   4
`define FLAG_ZERO  6
`define FLAG_SIGN  7
`define FLAG_OVF   11
`define FLAG_MASK  8'hd5

// cycle counts
`define CYC_ONE_REG 2
`define CYC_ONE_MEM 15
`define CYC_CNT_REG 5
`define CYC_CNT_MEM 17
`define CYC_LDFL    3

`define FLAGS_RESET 16'h0002
`endif

// ==== rtl/shift_unit_pkg.sv ====
// types shared by the shifter files
// assumes the map header is on the include path
package shift_unit_pkg;
	`include "shift_unit_map.svh"
	typedef enum logic [2:0] {
		OP_NONE  = 3'b001,
		OP_LEFT  = 3'b010,
		OP_RIGHT = 3'b100
	} shift_op_type;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_BUSY = 3'b010,
		ST_DONE = 3'b100
	} exec_state_type;
endpackage
